// *** hdl/oef_top.sv ***
`timescale 1ns/1ns
`default_nettype none

// usb otg event flag block with avalon-mm register slave
module oef_top #(
    parameter int MS_CYCLES = oef_pkg::MS_CYCLES // shorten in simulation
) (
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // usb pins and comparators, asynchronous
    input wire logic usb_id,
    input wire logic usb_dp,
    input wire logic usb_dm,
    input wire logic vbus_sess_valid,
    input wire logic vbus_above_sess_end,
    // flag levels toward interrupt logic
    output logic id_change_flag,
    output logic millisecond_tick_flag,
    output logic line_state_stable_flag,
    output logic bus_activity_wake_flag,
    output logic session_valid_change_flag,
    output logic session_end_change_flag,
    output logic bus_power_valid_change_flag,
    output logic irq
);

    localparam int MSW = $clog2(MS_CYCLES + 1); // counter width
    localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1); // terminal count

    // register state
    logic [7:0] otg_event_flags; // sticky flags, bit 1 held zero
    logic [7:0] irq_mask; // per-flag interrupt enable
    logic [1:0] ctrl; // timer enable, activity arm
    oef_pkg::oef_bus_state_t bus_state; // answer state of the slave

    // pin capture
    logic [oef_pkg::PIN_COUNT-1:0] pins_async; // raw pin vector
    logic [oef_pkg::PIN_COUNT-1:0] pins; // synchronised levels
    logic [oef_pkg::PIN_COUNT-1:0] pins_prev; // previous synchronised levels

    // event detection
    logic [7:0] set_vec; // hardware set requests this cycle
    logic [7:0] clr_vec; // software clear requests this cycle
    logic [7:0] next_flags; // flag value after this edge
    logic [MSW-1:0] ms_count; // millisecond timer
    logic ms_expire; // timer terminal count this cycle
    logic [MSW-1:0] ls_count; // line stability counter
    logic ls_done; // stability already judged for this state
    logic [1:0] line_recorded; // last stable line state recorded
    logic ls_expire; // line held for the full period now
    logic [1:0] line_now; // d+ and d- synchronised

    // bus decode
    logic bus_req; // a read or write is waiting
    logic bus_commit; // request completes at this edge
    logic wr_flags; // committed write to flag register
    logic wr_mask; // committed write to mask register
    logic wr_ctrl; // committed write to control register
    logic [31:0] next_readdata; // data for the pending read

    assign pins_async = {vbus_above_sess_end, vbus_sess_valid, usb_dm, usb_dp, usb_id};

    // every pin passes two flops before any logic looks at it
    oef_sync #(
        .WIDTH(oef_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(pins_async),
        .sync_out(pins)
    );

    // previous levels for edge detection; reset equals sync reset so no
    // false edge appears on release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pins_prev <= '0;
        end
        else
        begin
            pins_prev <= pins;
        end
    end

    assign line_now = {pins[oef_pkg::PIN_DP], pins[oef_pkg::PIN_DM]};

    // millisecond timer, free running while enabled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ms_count <= '0;
        end
        else if (!ctrl[oef_pkg::CTRL_TIMER_EN])
        begin
            // disabled: restart a full period on the next enable
            ms_count <= '0;
        end
        else if (ms_count == MS_LAST)
        begin
            ms_count <= '0; // see RULE2
        end
        else
        begin
            ms_count <= ms_count + MSW'(1);
        end
    end

    assign ms_expire = ctrl[oef_pkg::CTRL_TIMER_EN] && (ms_count == MS_LAST);

    // line stability: count while d+/d- hold, judge once per held state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ls_count <= '0;
            ls_done <= 1'b0;
            line_recorded <= oef_pkg::LINE_RESET;
        end
        else if (line_now != {pins_prev[oef_pkg::PIN_DP], pins_prev[oef_pkg::PIN_DM]})
        begin
            // any movement restarts the window
            ls_count <= '0;
            ls_done <= 1'b0;
        end
        else if (!ls_done)
        begin
            if (ls_count == MS_LAST)
            begin
                ls_done <= 1'b1;
                line_recorded <= line_now; // see RULE3
            end
            else
            begin
                ls_count <= ls_count + MSW'(1);
            end
        end
    end

    // a state equal to the recorded one stays silent even when stable
    assign ls_expire = !ls_done && (ls_count == MS_LAST)
        && (line_now == {pins_prev[oef_pkg::PIN_DP], pins_prev[oef_pkg::PIN_DM]});

    // hardware set requests, one per flag
    always_comb
    begin
        set_vec = 8'h00;
        // id pin moved
        set_vec[oef_pkg::BIT_ID] = pins[oef_pkg::PIN_ID] ^ pins_prev[oef_pkg::PIN_ID]; // see RULE1
        set_vec[oef_pkg::BIT_MS] = ms_expire; // see RULE2
        set_vec[oef_pkg::BIT_LSTATE] = ls_expire && (line_now != line_recorded); // see RULE3
        // armed and any watched line moved
        set_vec[oef_pkg::BIT_ACTV] = ctrl[oef_pkg::CTRL_ACT_ARM] && (pins != pins_prev); // see RULE4
        // vbus fell below session end
        set_vec[oef_pkg::BIT_SESVD] = pins_prev[oef_pkg::PIN_ABOVE_SESS_END]
            && !pins[oef_pkg::PIN_ABOVE_SESS_END]; // see RULE5
        set_vec[oef_pkg::BIT_SESEND] = pins[oef_pkg::PIN_ABOVE_SESS_END]
            ^ pins_prev[oef_pkg::PIN_ABOVE_SESS_END]; // see RULE6
        set_vec[oef_pkg::BIT_VBUSVD] = pins[oef_pkg::PIN_SESS_VALID]
            ^ pins_prev[oef_pkg::PIN_SESS_VALID]; // see RULE7
    end

    // avalon decode; a request completes on its second edge
    assign bus_req = avs_read || avs_write;
    assign bus_commit = bus_req && !avs_waitrequest;
    assign wr_flags = bus_commit && avs_write && (avs_address == oef_pkg::OFS_FLAGS) && avs_byteenable[0];
    assign wr_mask = bus_commit && avs_write && (avs_address == oef_pkg::OFS_MASK) && avs_byteenable[0];
    assign wr_ctrl = bus_commit && avs_write && (avs_address == oef_pkg::OFS_CTRL) && avs_byteenable[0];

    // write one clears, zero leaves the flag alone
    assign clr_vec = wr_flags ? avs_writedata[7:0] : 8'h00; // see RULE8

    // set is or-ed after the clear so a simultaneous event survives
    assign next_flags = ((otg_event_flags & ~clr_vec) | set_vec) & oef_pkg::FLAG_IMPL; // see RULE10

    // sticky flag register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            otg_event_flags <= oef_pkg::FLAGS_RESET; // see RULE8
        end
        else
        begin
            otg_event_flags <= next_flags; // see RULE10
        end
    end

    // mask register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_mask <= oef_pkg::MASK_RESET;
        end
        else if (wr_mask)
        begin
            irq_mask <= avs_writedata[7:0] & oef_pkg::FLAG_IMPL;
        end
    end

    // control register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= oef_pkg::CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl <= avs_writedata[1:0];
        end
    end

    // interrupt level, one cycle behind the flags
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(otg_event_flags & irq_mask);
        end
    end

    // read mux; unmapped or misaligned reads answer zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            oef_pkg::OFS_FLAGS: next_readdata[7:0] = otg_event_flags & oef_pkg::FLAG_IMPL; // see RULE9
            oef_pkg::OFS_MASK: next_readdata[7:0] = irq_mask;
            oef_pkg::OFS_CTRL: next_readdata[1:0] = ctrl;
            oef_pkg::OFS_LIVE: next_readdata[oef_pkg::PIN_COUNT-1:0] = pins;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // slave handshake: one wait cycle, then release on the commit edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_state <= oef_pkg::OEF_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            case (bus_state)
                oef_pkg::OEF_BUS_IDLE:
                begin
                    if (bus_req)
                    begin
                        // data captured here stands through the commit edge
                        bus_state <= oef_pkg::OEF_BUS_DONE;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
                    end
                end
                oef_pkg::OEF_BUS_DONE:
                begin
                    // master samples waitrequest low at this edge
                    bus_state <= oef_pkg::OEF_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state <= oef_pkg::OEF_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // flag levels straight from the flag flops
    assign id_change_flag = otg_event_flags[oef_pkg::BIT_ID]; // see RULE11
    assign millisecond_tick_flag = otg_event_flags[oef_pkg::BIT_MS];
    assign line_state_stable_flag = otg_event_flags[oef_pkg::BIT_LSTATE];
    assign bus_activity_wake_flag = otg_event_flags[oef_pkg::BIT_ACTV];
    assign session_valid_change_flag = otg_event_flags[oef_pkg::BIT_SESVD];
    assign session_end_change_flag = otg_event_flags[oef_pkg::BIT_SESEND];
    assign bus_power_valid_change_flag = otg_event_flags[oef_pkg::BIT_VBUSVD];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // two-step slave answer
    sequence s_req_waiting;
        bus_req && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_one_wait: assert property (s_req_waiting |=> s_answer)
        else $error("slave did not answer after one wait cycle");

    a_id_change_set: assert property ( // see RULE1
        (pins[oef_pkg::PIN_ID] != pins_prev[oef_pkg::PIN_ID]) |=> id_change_flag)
        else $error("id change not flagged");

    a_ms_tick_period: assert property ( // see RULE2
        (ctrl[oef_pkg::CTRL_TIMER_EN] && ms_count == MS_LAST) |=> millisecond_tick_flag && ms_count == '0)
        else $error("timer expiry not flagged");

    a_line_stable_set: assert property ( // see RULE3
        (ls_expire && line_now != line_recorded) |=> line_state_stable_flag && line_recorded == $past(line_now))
        else $error("stable line state not flagged");

    a_activity_wake: assert property ( // see RULE4
        (ctrl[oef_pkg::CTRL_ACT_ARM] && pins != pins_prev) |=> bus_activity_wake_flag)
        else $error("bus activity not flagged");

    a_vbus_drop_set: assert property ( // see RULE5
        (pins_prev[oef_pkg::PIN_ABOVE_SESS_END] && !pins[oef_pkg::PIN_ABOVE_SESS_END])
        |=> session_valid_change_flag && session_end_change_flag)
        else $error("vbus drop not flagged");

    a_sess_end_edge: assert property ( // see RULE6
        $changed(pins[oef_pkg::PIN_ABOVE_SESS_END]) |-> ##[1:2] session_end_change_flag)
        else $error("session end edge not flagged");

    a_sess_valid_edge: assert property ( // see RULE7
        $changed(pins[oef_pkg::PIN_SESS_VALID]) |-> ##[1:2] bus_power_valid_change_flag)
        else $error("session valid edge not flagged");

    a_no_soft_set: assert property ( // see RULE8
        1'b1 |=> ((otg_event_flags & ~$past(otg_event_flags) & ~$past(set_vec)) == 8'h00))
        else $error("flag set without a hardware event");

    a_w1c_clears: assert property ( // see RULE8
        (wr_flags && (avs_writedata[7:0] & ~set_vec & oef_pkg::FLAG_IMPL) != 8'h00)
        |=> ((otg_event_flags & $past(avs_writedata[7:0]) & ~$past(set_vec)) == 8'h00))
        else $error("write one did not clear");

    a_reserved_zero: assert property ( // see RULE9
        avs_readdata[31:8] == 24'h00_0000 && !otg_event_flags[1])
        else $error("reserved bit nonzero");

    a_set_beats_clear: assert property ( // see RULE10
        ((set_vec & clr_vec) != 8'h00)
        |=> ((otg_event_flags & $past(set_vec) & $past(clr_vec)) == ($past(set_vec) & $past(clr_vec))))
        else $error("clear overrode a set");

    a_irq_level: assert property ( // see RULE11
        1'b1 |=> irq == |($past(otg_event_flags) & $past(irq_mask)))
        else $error("interrupt level wrong");

endmodule : oef_top

`default_nettype wire

// *** shared/oef_pkg.sv ***
// What this block does
// RULE1 - flag id pin state changes
// RULE2 - run 1 ms timer, flag expiry
// RULE3 - flag line state stable 1 ms, new
// RULE4 - flag bus activity that wakes device
// RULE5 - flag vbus falling below session end
// RULE6 - flag any session end comparator edge
// RULE7 - flag any session valid comparator edge
// RULE8 - hardware sets, write one clears, reset zero
// RULE9 - bits 31..8 and 1 read zero
// RULE10 - flags sticky; set beats clear
// RULE11 - each flag a level output
`default_nettype none

package oef_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 40; // 25 MHz peripheral clock
    localparam int MS_TIME_NS = 1000000; // one millisecond
    // timer period in cycles, rounded up to whole cycles
    localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [3:0] OFS_FLAGS = 4'h0; // sticky event flags
    localparam logic [3:0] OFS_MASK = 4'h4; // interrupt mask
    localparam logic [3:0] OFS_CTRL = 4'h8; // control bits
    localparam logic [3:0] OFS_LIVE = 4'hC; // live synchronised pin levels

    // flag bit positions
    localparam int BIT_ID = 7;
    localparam int BIT_MS = 6;
    localparam int BIT_LSTATE = 5;
    localparam int BIT_ACTV = 4;
    localparam int BIT_SESVD = 3;
    localparam int BIT_SESEND = 2;
    localparam int BIT_VBUSVD = 0;

    // implemented flag bits, bit 1 is unimplemented
    localparam logic [7:0] FLAG_IMPL = 8'hFD;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // control register fields
    localparam int CTRL_TIMER_EN = 0; // run the millisecond timer
    localparam int CTRL_ACT_ARM = 1; // arm wake-up activity detection
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // live pin vector positions
    localparam int PIN_ID = 0;
    localparam int PIN_DP = 1;
    localparam int PIN_DM = 2;
    localparam int PIN_SESS_VALID = 3;
    localparam int PIN_ABOVE_SESS_END = 4;
    localparam int PIN_COUNT = 5;
    localparam logic [1:0] LINE_RESET = 2'h0;

    // register bus answer state
    typedef enum logic [0:0] {
        OEF_BUS_IDLE = 1'b0,
        OEF_BUS_DONE = 1'b1
    } oef_bus_state_t;

endpackage : oef_pkg

`default_nettype wire

// *** hdl/oef_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for a vector of asynchronous levels
module oef_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1; // metastable stage, read only by stage two

    // both stages clear on reset; pins are never sampled under reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : oef_sync

`default_nettype wire

// *** sim/oef_usb_peer.sv ***
`timescale 1ns/1ns
`default_nettype none

// usb cable and attached peer: id pin, d+ and d-, and the two vbus comparators
module oef_usb_peer (
    input wire logic clk,
    output logic usb_id,
    output logic usb_dp,
    output logic usb_dm,
    output logic vbus_sess_valid,
    output logic vbus_above_sess_end
);
    // pin levels, all low as for an unplugged cable
    logic [oef_pkg::PIN_COUNT-1:0] lvl = 5'h00;

    // same bit order as the live register, so tables read alike
    assign usb_id = lvl[oef_pkg::PIN_ID];
    assign usb_dp = lvl[oef_pkg::PIN_DP];
    assign usb_dm = lvl[oef_pkg::PIN_DM];
    assign vbus_sess_valid = lvl[oef_pkg::PIN_SESS_VALID];
    assign vbus_above_sess_end = lvl[oef_pkg::PIN_ABOVE_SESS_END];

    // levels move just after an edge; the block treats them as asynchronous anyway
    task automatic drive(input logic [oef_pkg::PIN_COUNT-1:0] v);
        @(posedge clk);
        lvl <= v;
    endtask : drive
endmodule : oef_usb_peer

`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

// one compare: counts it, reports a mismatch at once
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module tb_top;
    localparam int MS = 20; // shortened millisecond keeps the run brief
    localparam logic [3:0] FL = oef_pkg::OFS_FLAGS;
    localparam logic [3:0] MK = oef_pkg::OFS_MASK;
    localparam logic [3:0] CT = oef_pkg::OFS_CTRL;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic usb_id, usb_dp, usb_dm, vbus_sess_valid, vbus_above_sess_end;
    logic id_f, ms_f, ls_f, act_f, sv_f, se_f, bp_f, irq;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] rd; // last read data

    oef_top #(.MS_CYCLES(MS)) u_oef_top (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .usb_id(usb_id), .usb_dp(usb_dp), .usb_dm(usb_dm), .vbus_sess_valid(vbus_sess_valid),
        .vbus_above_sess_end(vbus_above_sess_end), .id_change_flag(id_f), .millisecond_tick_flag(ms_f),
        .line_state_stable_flag(ls_f), .bus_activity_wake_flag(act_f), .session_valid_change_flag(sv_f),
        .session_end_change_flag(se_f), .bus_power_valid_change_flag(bp_f), .irq(irq));

    oef_usb_peer u_oef_usb_peer (.clk(clk), .usb_id(usb_id), .usb_dp(usb_dp), .usb_dm(usb_dm),
        .vbus_sess_valid(vbus_sess_valid), .vbus_above_sess_end(vbus_above_sess_end));

    // 25 MHz clock
    initial
    begin
        forever #20 clk = ~clk;
    end

    // flag outputs gathered in register layout, bit 1 unused
    function automatic logic [7:0] flag_vec();
        return {id_f, ms_f, ls_f, act_f, sv_f, se_f, 1'b0, bp_f};
    endfunction : flag_vec

    // counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // a slave that never answers ends the run
        if (avs_waitrequest !== 1'b0)
        begin
            errors++;
            give_verdict();
        end
    endtask : bus

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rd, exp)
    endtask : rdchk

    // bounded wait until the flag outputs show exp
    task automatic wait_flags(input logic [7:0] exp, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (flag_vec() !== exp && n < 80);
        `CHK(flag_vec(), exp)
        // a flag that never showed ends the run
        if (flag_vec() !== exp)
        begin
            give_verdict();
        end
    endtask : wait_flags

    // new pin levels, expect exactly exp, then clear by writing ones back
    task automatic step(input logic [4:0] pins, input logic [7:0] exp, output int n);
        u_oef_usb_peer.drive(pins);
        wait_flags(exp, n);
        rdchk(FL, {24'h00_0000, exp});
        bus(1'b1, FL, {24'h00_0000, exp});
        rdchk(FL, 32'h0000_0000);
    endtask : step

    // reset values, and software unable to set anything
    task automatic t_reset();
        rdchk(FL, 32'h0000_0000);
        rdchk(MK, 32'h0000_0000);
        rdchk(CT, 32'h0000_0000);
        `CHK(irq, 1'b0)
        bus(1'b1, FL, 32'hFFFF_FFFF);
        rdchk(FL, 32'h0000_0000);
    endtask : t_reset

    // id pin and both vbus comparator edges, in both directions
    task automatic t_pins();
        logic [4:0] p [6] = '{5'h01, 5'h00, 5'h10, 5'h00, 5'h08, 5'h00};
        logic [7:0] e [6] = '{8'h80, 8'h80, 8'h04, 8'h0C, 8'h01, 8'h01};
        int n;
        for (int i = 0; i < 6; i++)
        begin
            step(p[i], e[i], n);
            rdchk(oef_pkg::OFS_LIVE, {27'h000_0000, p[i]});
        end
    endtask : t_pins

    // zero writes, lane off, unmapped place, stickiness and the interrupt
    task automatic t_sticky_irq();
        int n;
        u_oef_usb_peer.drive(5'h01);
        wait_flags(8'h80, n);
        bus(1'b1, FL, 32'hFFFF_FF7F);
        rdchk(FL, 32'h0000_0080);
        avs_byteenable <= 4'h0;
        bus(1'b1, FL, 32'h0000_0080);
        avs_byteenable <= 4'hf;
        rdchk(FL, 32'h0000_0080);
        rdchk(4'h2, 32'h0000_0000);
        repeat (3 * MS) @(posedge clk);
        rdchk(FL, 32'h0000_0080);
        `CHK(irq, 1'b0)
        bus(1'b1, MK, 32'h0000_0080);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        rdchk(MK, 32'h0000_0080);
        bus(1'b1, FL, 32'h0000_0080);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        bus(1'b1, MK, 32'h0000_0000);
        step(5'h00, 8'h80, n);
    endtask : t_sticky_irq

    // line state: only after a full stable window, and once per new state
    task automatic t_line();
        int n;
        step(5'h02, 8'h20, n);
        `CHK(n >= MS, 1'b1)
        repeat (3 * MS) @(posedge clk);
        `CHK(flag_vec(), 8'h00)
        step(5'h00, 8'h20, n);
        `CHK(n >= MS, 1'b1)
    endtask : t_line

    // activity only while armed
    task automatic t_act();
        int n;
        bus(1'b1, CT, 32'h0000_0002);
        step(5'h01, 8'h90, n);
        bus(1'b1, CT, 32'h0000_0000);
        step(5'h00, 8'h80, n);
    endtask : t_act

    // periodic tick while enabled, silence once stopped
    task automatic t_timer();
        int n;
        bus(1'b1, CT, 32'h0000_0001);
        wait_flags(8'h40, n);
        `CHK(n, MS + 1)
        bus(1'b1, FL, 32'h0000_0040);
        wait_flags(8'h40, n);
        // land a clear on the very edge of the next tick: the set must win
        repeat (MS - 4) @(posedge clk);
        bus(1'b1, FL, 32'h0000_0040);
        rdchk(FL, 32'h0000_0040);
        bus(1'b1, CT, 32'h0000_0000);
        bus(1'b1, FL, 32'h0000_0040);
        repeat (3 * MS) @(posedge clk);
        rdchk(FL, 32'h0000_0000);
    endtask : t_timer

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_pins();
        t_sticky_irq();
        t_line();
        t_act();
        t_timer();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
